// [inc/tcd_pkg.sv]
package tcd_pkg;
   localparam logic [13:0] ADR_CR   = 14'h0000;
   localparam logic [13:0] ADR_BPM  = 14'h0002;
   localparam logic [13:0] ADR_BOAR = 14'h001C;
   localparam logic [13:0] ADR_LOAR = 14'h0020;
   localparam logic [13:0] ADR_LBER = 14'h0028;
   localparam logic [13:0] ADR_BBER = 14'h002A;
   localparam int MEM_SPACE_BIT = 13;

   localparam int CR_MS_LSB     = 0;
   localparam int CR_MBP_BIT    = 3;
   localparam int BPM_START_BIT = 0;
   localparam int BPM_LPAT_LSB  = 3;
   localparam int BPM_BPAT_LSB  = 6;
   localparam int CM_MODE_LSB   = 13;
   localparam logic [15:0] CR_RST  = 16'h0000;
   localparam logic [15:0] BPM_RST = 16'h0000;
   localparam logic [15:0] ADV_RST = 16'h0000;

   // transfer mode code bits
   localparam int TM_CONST_BIT  = 0;
   localparam int TM_BP_SRC_BIT = 1;
   localparam int TM_OFF_BIT    = 2;

   localparam logic [2:0] MS_LCM = 3'h0;
   localparam logic [2:0] MS_BCM = 3'h1;
   localparam logic [2:0] MS_LDM = 3'h2;
   localparam logic [2:0] MS_BDM = 3'h3;

   localparam logic [1:0] RATE_4M = 2'h1;
   localparam logic [1:0] RATE_2M = 2'h2;
   localparam int DLY_2M = 3;
   localparam int DLY_4M = 5;
   localparam int DLY_8M = 10;

   localparam int PAGES        = 3;
   localparam int CLK_PS       = 10000;
   localparam int ADV_STEP_PS  = 7500;
   localparam int ADV_STEP_CYC = (ADV_STEP_PS + CLK_PS - 1) / CLK_PS;
   localparam int BP_ADV_REGS  = 4;
   localparam int LOC_ADV_REGS = 2;

   localparam int SLOT_BITS_DEF = 11;
   localparam int CH_CYC_DEF    = 8;
   localparam int PIPE_BP_RD    = 1;
   localparam int PIPE_BP_CAP   = 2;
   localparam int PIPE_LOC_CAP  = 3;
   localparam logic [7:0] IDLE_BYTE = 8'hFF;

   typedef enum logic [1:0] {H_IDLE, H_ACC, H_RD, H_ACK} tcd_host_st_t;
endpackage

// [sim/tcd_host.sv]
module tcd_host (
   input  wire logic        clk_in,    // clock
   input  wire logic        ack_n_in,  // acknowledge level
   input  wire logic        ack_oe_in, // acknowledge drive
   input  wire logic        rd_oe_in,  // read data drive
   input  wire logic [15:0] rd_in,     // read data
   output logic             cs_n_out,  // chip select
   output logic             ds_n_out,  // data strobe
   output logic             rnw_out,   // 1 read
   output logic      [13:0] a_out,     // address
   output logic      [15:0] wd_out     // write data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic ack_w;
   // pull-up holds the line high once released
   assign ack_w = ack_oe_in ? ack_n_in : 1'b1;
   initial {cs_n_out, ds_n_out, rnw_out, a_out, wd_out} = {3'h7, 14'h0000, 16'h0000};
   task automatic access(input logic r, input logic [13:0] ad, input logic [15:0] w,
                         output logic [15:0] rd, output logic ok);
      int n;
      n = 0;
      @(posedge clk_in);
      {cs_n_out, ds_n_out, rnw_out, a_out} <= {2'h0, r, ad};
      wd_out <= r ? ~wd_out : w;
      do begin
         @(posedge clk_in);
         n++;
      end while (ack_w !== 1'b0 && n < 3000);
      rd = rd_oe_in ? rd_in : ~rd_in;
      ok = (n < 3000);
      {cs_n_out, ds_n_out} <= 2'h3;
      repeat (2) @(posedge clk_in);
      if (ack_oe_in !== 1'b0) ok = 1'b0;
   endtask
endmodule

// [sim/test_tsi_connection_delay_control.sv]
module test_tsi_connection_delay_control
   import tcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, fp, cs_n, ds_n, rnw, doe, ackn, ackoe, busy;
   logic [1:0]  rate;
   logic [7:0]  lin, bin;
   logic [13:0] a;
   logic [15:0] wd, rd, lerr, berr, v;
   int          failures, samples_checked, cyc;

   tcd_core #(.SLOT_BITS(5), .CH_CYC(8)) dut (
      .ref_clk_in(clk), .reset_in(rst), .frame_pulse_in(fp), .local_rate_in(rate),
      .local_in_data_in(lin), .bp_in_data_in(bin), .local_out_data_out(),
      .bp_out_data_out(), .local_out_strobe_out(), .bp_out_strobe_out(),
      .local_error_count_in(lerr), .backplane_error_count_in(berr),
      .chip_select_n_in(cs_n), .data_strobe_n_in(ds_n), .read_not_write_in(rnw),
      .host_address_bus_in(a), .host_data_bus_in(wd), .host_data_bus_out(rd),
      .host_data_bus_oe_out(doe), .transfer_acknowledge_n_out(ackn),
      .transfer_acknowledge_n_oe_out(ackoe), .init_busy_out(busy));
   tcd_host host (.clk_in(clk), .ack_n_in(ackn), .ack_oe_in(ackoe), .rd_oe_in(doe),
      .rd_in(rd), .cs_n_out(cs_n), .ds_n_out(ds_n), .rnw_out(rnw), .a_out(a), .wd_out(wd));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // frame of 32 slots of 8 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      fp <= (cyc % 256 == 255);
      lin <= 8'(cyc);
      bin <= ~8'(cyc);
   end

   task automatic check16(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run();
      $display("checked %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic bus(input logic r, input logic [13:0] ad, input logic [15:0] w);
      logic ok;
      host.access(r, ad, w, v, ok);
      if (ok !== 1'b1) begin
         failures++;
         $display("[ERR] bus_cycle expected 1 seen 0");
         complete_run();
      end
   endtask
   task automatic t_regs();
      bus(0, ADR_BOAR + 14'h0003, 16'hE41B);
      bus(0, ADR_LOAR + 14'h0001, 16'h1BE4);
      bus(1, ADR_BOAR + 14'h0003, 16'h0000);
      check16("bp_advance_3", 16'hE41B, v);
      bus(1, ADR_LOAR + 14'h0001, 16'h0000);
      check16("local_advance_1", 16'h1BE4, v);
      bus(1, ADR_BOAR, 16'h0000);
      check16("bp_advance_0", ADV_RST, v);
      $display("test regs done");
   endtask
   task automatic t_ro();
      bus(0, ADR_LBER, 16'h0000);
      bus(0, ADR_BBER, 16'hFFFF);
      bus(1, ADR_LBER, 16'h0000);
      check16("local_err_count", 16'h1234, v);
      bus(1, ADR_BBER, 16'h0000);
      check16("bp_err_count", 16'h5678, v);
      bus(1, 14'h0003, 16'h0000);
      check16("unmapped_read", 16'h0000, v);
      $display("test read-only done");
   endtask
   task automatic t_init();
      int t0;
      bus(0, ADR_BPM, 16'h0171);
      repeat (20) @(posedge clk);
      check16("busy_without_mode", 16'h0000, {15'h0000, busy});
      bus(0, ADR_BPM, 16'h0000);
      bus(0, ADR_CR, 16'h0008);
      bus(0, ADR_BPM, 16'h0171);
      t0 = cyc;
      v = 16'h0001;
      for (int i = 0; i < 200 && v[0] !== 1'b0; i++) bus(1, ADR_BPM, 16'h0000);
      check16("start_bit_cleared", 16'h0170, v);
      check16("init_in_two_frames", 16'h0001, 16'(cyc - t0 <= 512));
      bus(0, ADR_CR, {13'h0000, MS_LCM});
      bus(1, 14'h2003, 16'h0000);
      check16("local_cm_entry", 16'hC000, v);
      bus(0, ADR_CR, {13'h0000, MS_BCM});
      bus(1, 14'h201D, 16'h0000);
      check16("bp_cm_entry", 16'hA000, v);
      bus(0, 14'h2007, 16'h4005);
      bus(1, 14'h2007, 16'h0000);
      check16("bp_cm_write", 16'h4005, v);
      $display("test init done");
   endtask

   initial begin
      {rst, fp, rate, lin, bin} = {1'b1, 1'b0, 2'h0, 8'h00, 8'hFF};
      {lerr, berr, cyc} = {16'h1234, 16'h5678, 32'h0};
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_ro();
      t_init();
      complete_run();
   end
endmodule

// [verilog/tcd_core.sv]
module tcd_core
   import tcd_pkg::*;
#(
   parameter int SLOT_BITS = SLOT_BITS_DEF,
   parameter int CH_CYC    = CH_CYC_DEF
) (
   input  wire logic        ref_clk_in,                   // 100 MHz clock
   input  wire logic        reset_in,                     // sync reset, high
   input  wire logic        frame_pulse_in,               // frame boundary pulse
   input  wire logic [1:0]  local_rate_in,                // local data rate code
   input  wire logic [7:0]  local_in_data_in,             // local input channel byte
   input  wire logic [7:0]  bp_in_data_in,                // backplane input byte
   output logic      [7:0]  local_out_data_out,           // local output byte
   output logic      [7:0]  bp_out_data_out,              // backplane output byte
   output logic             local_out_strobe_out,         // local byte loaded, once per slot
   output logic             bp_out_strobe_out,            // backplane byte loaded, once per slot
   input  wire logic [15:0] local_error_count_in,         // local error count
   input  wire logic [15:0] backplane_error_count_in,     // backplane error count
   input  wire logic        chip_select_n_in,             // host chip select
   input  wire logic        data_strobe_n_in,             // host data strobe
   input  wire logic        read_not_write_in,            // 1 read, 0 write
   input  wire logic [13:0] host_address_bus_in,          // host address
   input  wire logic [15:0] host_data_bus_in,             // host data in
   output logic      [15:0] host_data_bus_out,            // host data out
   output logic             host_data_bus_oe_out,         // host data drive
   output logic             transfer_acknowledge_n_out,   // acknowledge level
   output logic             transfer_acknowledge_n_oe_out,// acknowledge drive
   output logic             init_busy_out                 // block init running
);
   localparam int CYC_W      = $clog2(CH_CYC);
   localparam int AW_DM      = SLOT_BITS + 2;
   localparam int INIT_LIMIT = 2 * (2 ** SLOT_BITS) * CH_CYC;

   function automatic logic [1:0] page_inc(input logic [1:0] p);
      return (p == 2'(PAGES - 1)) ? 2'h0 : p + 2'h1;
   endfunction

   function automatic logic [1:0] page_dec(input logic [1:0] p);
      return (p == 2'h0) ? 2'(PAGES - 1) : p - 2'h1;
   endfunction

   function automatic logic [1:0] adv_of(input logic [15:0] r, input logic [2:0] f);
      return r[{f, 1'b0} +: 2];
   endfunction

   function automatic int load_cyc(input logic [1:0] adv);
      return CH_CYC - 1 - int'(adv) * ADV_STEP_CYC;
   endfunction

   // data memory address for one output channel
   function automatic logic [AW_DM-1:0] src_addr(input logic [15:0] cm,
                                                 input logic [SLOT_BITS-1:0] dst,
                                                 input logic [1:0] wp,
                                                 input int min_dly);
      logic [SLOT_BITS-1:0] src;
      logic [1:0]           pg;
      src = cm[SLOT_BITS-1:0];
      if (cm[CM_MODE_LSB + TM_CONST_BIT]) begin
         pg = page_inc(wp);
      end else if (int'(src) + min_dly <= int'(dst)) begin
         pg = wp;
      end else begin
         pg = page_dec(wp);
      end
      return {pg, src};
   endfunction

   function automatic logic [7:0] sel_byte(input logic [15:0] cm,
                                           input logic [7:0] l,
                                           input logic [7:0] b);
      if (cm[CM_MODE_LSB + TM_OFF_BIT]) begin
         return IDLE_BYTE;
      end
      return cm[CM_MODE_LSB + TM_BP_SRC_BIT] ? b : l;
   endfunction

   logic [CYC_W-1:0]     cyc_q;
   logic [SLOT_BITS-1:0] slot_q;
   logic [SLOT_BITS-1:0] nxt;
   logic [1:0]           wp_q;
   logic [1:0]           wp_n;
   logic [15:0]          cr_q;
   logic [15:0]          bpm_q;
   logic [15:0]          bp_adv_q [BP_ADV_REGS];
   logic [15:0]          loc_adv_q [LOC_ADV_REGS];
   logic                 init_busy_q;
   logic [SLOT_BITS-1:0] iaddr_q;
   logic                 init_done;
   int                   init_len_q;
   tcd_host_st_t         hst_q;
   logic                 sel;
   logic                 is_mem;
   logic                 rd;
   logic                 ready;
   logic                 hacc;
   logic                 hwr;
   logic                 wr_reg;
   logic [2:0]           ms;
   logic [SLOT_BITS-1:0] slot_h;
   logic [15:0]          reg_rdata;
   logic [15:0]          mem_rdata;
   logic [15:0]          host_rdata_q;
   logic [15:0]          lcm_a;
   logic [15:0]          bcm_a;
   logic [15:0]          lcm_b;
   logic [15:0]          bcm_b;
   logic [7:0]           ldm_a;
   logic [7:0]           bdm_a;
   logic [7:0]           ldm_b;
   logic [7:0]           bdm_b;
   logic                 cm_we_l;
   logic                 cm_we_b;
   logic [SLOT_BITS-1:0] cm_addr;
   logic [15:0]          lcm_wd;
   logic [15:0]          bcm_wd;
   logic                 dm_we;
   logic [AW_DM-1:0]     dm_a_addr;
   logic [AW_DM-1:0]     dm_b_addr;
   int                   loc_min;
   logic [7:0]           bp_byte_q;
   logic [7:0]           loc_byte_q;
   logic [1:0]           bp_adv;
   logic [1:0]           loc_adv;
   logic                 bp_load;
   logic                 loc_load;

   // slot and frame timing
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         cyc_q  <= '0;
         slot_q <= '0;
         wp_q   <= 2'h0;
      end else if (frame_pulse_in) begin
         cyc_q  <= '0;
         slot_q <= '0;
         wp_q   <= page_inc(wp_q);
      end else if (int'(cyc_q) == CH_CYC - 1) begin
         cyc_q  <= '0;
         slot_q <= nxt;
      end else begin
         cyc_q <= cyc_q + 1'b1;
      end
   end

   assign nxt  = slot_q + 1'b1;
   assign wp_n = (nxt == '0) ? page_inc(wp_q) : wp_q;

   always_comb begin
      unique case (local_rate_in)
         RATE_2M: loc_min = DLY_2M;
         RATE_4M: loc_min = DLY_4M;
         default: loc_min = DLY_8M;
      endcase
   end

   // host port decode
   assign sel    = !chip_select_n_in && !data_strobe_n_in;
   assign is_mem = host_address_bus_in[MEM_SPACE_BIT];
   assign rd     = read_not_write_in;
   assign ms     = cr_q[CR_MS_LSB +: 3];
   assign slot_h = host_address_bus_in[SLOT_BITS-1:0];
   assign ready  = !is_mem || (!init_busy_q && cyc_q != '0);
   assign hacc   = hst_q == H_ACC && sel && ready;
   assign hwr    = hacc && !rd;
   assign wr_reg = hwr && !is_mem;

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         hst_q <= H_IDLE;
      end else begin
         unique case (hst_q)
            H_IDLE: if (sel) begin
               hst_q <= H_ACC;
            end
            H_ACC: if (!sel) begin
               hst_q <= H_IDLE;
            end else if (ready) begin
               hst_q <= (rd && is_mem) ? H_RD : H_ACK;
            end
            H_RD: hst_q <= H_ACK;
            H_ACK: if (!sel) begin
               hst_q <= H_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         host_rdata_q <= 16'h0000;
      end else if (hacc && rd && !is_mem) begin
         host_rdata_q <= reg_rdata;
      end else if (hst_q == H_RD) begin
         host_rdata_q <= mem_rdata;
      end
   end

   assign host_data_bus_out             = host_rdata_q;
   assign host_data_bus_oe_out          = hst_q == H_ACK && rd;
   assign transfer_acknowledge_n_out    = 1'b0;
   assign transfer_acknowledge_n_oe_out = hst_q == H_ACK;

   always_comb begin
      reg_rdata = 16'h0000;
      if (host_address_bus_in == ADR_CR) begin
         reg_rdata = cr_q;
      end else if (host_address_bus_in == ADR_BPM) begin
         reg_rdata = bpm_q;
      end else if (host_address_bus_in[13:2] == ADR_BOAR[13:2]) begin
         reg_rdata = bp_adv_q[host_address_bus_in[1:0]];
      end else if (host_address_bus_in[13:1] == ADR_LOAR[13:1]) begin
         reg_rdata = loc_adv_q[host_address_bus_in[0]];
      end else if (host_address_bus_in == ADR_LBER) begin
         reg_rdata = local_error_count_in;
      end else if (host_address_bus_in == ADR_BBER) begin
         reg_rdata = backplane_error_count_in;
      end
   end

   always_comb begin
      unique case (ms)
         MS_LCM:  mem_rdata = lcm_a;
         MS_BCM:  mem_rdata = bcm_a;
         MS_LDM:  mem_rdata = {8'h00, ldm_a};
         MS_BDM:  mem_rdata = {8'h00, bdm_a};
         default: mem_rdata = 16'h0000;
      endcase
   end

   // control registers; error counts and data memory take no writes
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         cr_q <= CR_RST;
      end else if (wr_reg && host_address_bus_in == ADR_CR) begin
         cr_q <= host_data_bus_in;
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         bpm_q <= BPM_RST;
      end else begin
         if (wr_reg && host_address_bus_in == ADR_BPM) begin
            bpm_q <= host_data_bus_in;
         end
         if (init_done && !(wr_reg && host_address_bus_in == ADR_BPM
                            && host_data_bus_in[BPM_START_BIT])) begin
            bpm_q[BPM_START_BIT] <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         for (int i = 0; i < BP_ADV_REGS; i++) begin
            bp_adv_q[i] <= ADV_RST;
         end
         for (int i = 0; i < LOC_ADV_REGS; i++) begin
            loc_adv_q[i] <= ADV_RST;
         end
      end else if (wr_reg && host_address_bus_in[13:2] == ADR_BOAR[13:2]) begin
         bp_adv_q[host_address_bus_in[1:0]] <= host_data_bus_in;
      end else if (wr_reg && host_address_bus_in[13:1] == ADR_LOAR[13:1]) begin
         loc_adv_q[host_address_bus_in[0]] <= host_data_bus_in;
      end
   end

   // block initialisation of both connection memories
   assign init_done = init_busy_q && iaddr_q == '1;

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         init_busy_q <= 1'b0;
         iaddr_q     <= '0;
      end else if (init_busy_q) begin
         iaddr_q <= iaddr_q + 1'b1;
         if (init_done) begin
            init_busy_q <= 1'b0;
         end
      end else if (cr_q[CR_MBP_BIT] && bpm_q[BPM_START_BIT]) begin
         init_busy_q <= 1'b1;
         iaddr_q     <= '0;
      end
   end

   assign init_busy_out = init_busy_q;

   always_comb begin
      cm_addr = init_busy_q ? iaddr_q : slot_h;
      lcm_wd  = host_data_bus_in;
      bcm_wd  = host_data_bus_in;
      if (init_busy_q) begin
         lcm_wd = {bpm_q[BPM_LPAT_LSB +: 3], 13'h0000};
         bcm_wd = {bpm_q[BPM_BPAT_LSB +: 3], 13'h0000};
      end
   end

   assign cm_we_l   = init_busy_q || (hwr && is_mem && ms == MS_LCM);
   assign cm_we_b   = init_busy_q || (hwr && is_mem && ms == MS_BCM);
   assign dm_we     = cyc_q == '0;
   assign dm_a_addr = dm_we ? {wp_q, slot_q} : {wp_q, slot_h};
   // backplane path reads the data memories first, local path one cycle later
   assign dm_b_addr = (int'(cyc_q) == PIPE_BP_RD) ? src_addr(bcm_b, nxt, wp_n, DLY_8M)
                                                  : src_addr(lcm_b, nxt, wp_n, loc_min);

   tcd_mem #(.DW(16), .AW(SLOT_BITS)) u_lcm (
      .ref_clk_in  (ref_clk_in),
      .a_we_in     (cm_we_l),
      .a_addr_in   (cm_addr),
      .a_wdata_in  (lcm_wd),
      .a_rdata_out (lcm_a),
      .b_addr_in   (nxt),
      .b_rdata_out (lcm_b)
   );

   tcd_mem #(.DW(16), .AW(SLOT_BITS)) u_bcm (
      .ref_clk_in  (ref_clk_in),
      .a_we_in     (cm_we_b),
      .a_addr_in   (cm_addr),
      .a_wdata_in  (bcm_wd),
      .a_rdata_out (bcm_a),
      .b_addr_in   (nxt),
      .b_rdata_out (bcm_b)
   );

   tcd_mem #(.DW(8), .AW(AW_DM)) u_ldm (
      .ref_clk_in  (ref_clk_in),
      .a_we_in     (dm_we),
      .a_addr_in   (dm_a_addr),
      .a_wdata_in  (local_in_data_in),
      .a_rdata_out (ldm_a),
      .b_addr_in   (dm_b_addr),
      .b_rdata_out (ldm_b)
   );

   tcd_mem #(.DW(8), .AW(AW_DM)) u_bdm (
      .ref_clk_in  (ref_clk_in),
      .a_we_in     (dm_we),
      .a_addr_in   (dm_a_addr),
      .a_wdata_in  (bp_in_data_in),
      .a_rdata_out (bdm_a),
      .b_addr_in   (dm_b_addr),
      .b_rdata_out (bdm_b)
   );

   // source side chosen by the transfer mode code
   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         bp_byte_q <= IDLE_BYTE;
      end else if (int'(cyc_q) == PIPE_BP_CAP) begin
         bp_byte_q <= sel_byte(bcm_b, ldm_b, bdm_b);
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         loc_byte_q <= IDLE_BYTE;
      end else if (int'(cyc_q) == PIPE_LOC_CAP) begin
         loc_byte_q <= sel_byte(lcm_b, ldm_b, bdm_b);
      end
   end

   // output advancement: the same cycle offset at every data rate
   assign bp_adv   = adv_of(bp_adv_q[nxt[SLOT_BITS-1 -: 2]], nxt[SLOT_BITS-3 -: 3]);
   assign loc_adv  = adv_of(loc_adv_q[nxt[SLOT_BITS-1]], nxt[SLOT_BITS-2 -: 3]);
   assign bp_load  = int'(cyc_q) == load_cyc(bp_adv);
   assign loc_load = int'(cyc_q) == load_cyc(loc_adv);

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         bp_out_data_out   <= IDLE_BYTE;
         bp_out_strobe_out <= 1'b0;
      end else begin
         bp_out_strobe_out <= bp_load;
         if (bp_load) begin
            bp_out_data_out <= bp_byte_q;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
         local_out_data_out   <= IDLE_BYTE;
         local_out_strobe_out <= 1'b0;
      end else begin
         local_out_strobe_out <= loc_load;
         if (loc_load) begin
            local_out_data_out <= loc_byte_q;
         end
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (reset_in || !init_busy_q) begin
         init_len_q <= 0;
      end else begin
         init_len_q <= init_len_q + 1;
      end
   end

   property p_init_start;
      @(posedge ref_clk_in) disable iff (reset_in)
      $rose(init_busy_q) |-> $past(cr_q[CR_MBP_BIT]) && $past(bpm_q[BPM_START_BIT]);
   endproperty
   a_init_start: assert property (p_init_start) else $error("init began without both bits");

   property p_init_len;
      @(posedge ref_clk_in) disable iff (reset_in)
      init_busy_q |-> init_len_q < INIT_LIMIT;
   endproperty
   a_init_len: assert property (p_init_len) else $error("init exceeded two frames");

   property p_init_clear;
      @(posedge ref_clk_in) disable iff (reset_in)
      $fell(init_busy_q) && !$past(wr_reg) |-> !bpm_q[BPM_START_BIT];
   endproperty
   a_init_clear: assert property (p_init_clear) else $error("start bit not cleared");

   property p_bp_pattern;
      @(posedge ref_clk_in) disable iff (reset_in)
      init_busy_q |-> cm_we_b && bcm_wd == {bpm_q[BPM_BPAT_LSB +: 3], 13'h0000};
   endproperty
   a_bp_pattern: assert property (p_bp_pattern) else $error("bad backplane init word");

   property p_loc_pattern;
      @(posedge ref_clk_in) disable iff (reset_in)
      init_busy_q |-> cm_we_l && lcm_wd[12:0] == 13'h0000 && cm_addr == iaddr_q;
   endproperty
   a_loc_pattern: assert property (p_loc_pattern) else $error("bad local init word");

   property p_ack_release;
      @(posedge ref_clk_in) disable iff (reset_in)
      transfer_acknowledge_n_oe_out && !sel |=> !transfer_acknowledge_n_oe_out;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("acknowledge not released");

   property p_dm_ro;
      @(posedge ref_clk_in) disable iff (reset_in)
      dm_we |-> dm_a_addr == {wp_q, slot_q} && !(hst_q == H_RD && $past(dm_we));
   endproperty
   a_dm_ro: assert property (p_dm_ro) else $error("data memory written off slot start");

   property p_const_page;
      @(posedge ref_clk_in) disable iff (reset_in)
      int'(cyc_q) == PIPE_BP_RD && bcm_b[CM_MODE_LSB + TM_CONST_BIT]
         |-> dm_b_addr[AW_DM-1 -: 2] == page_inc(wp_n);
   endproperty
   a_const_page: assert property (p_const_page) else $error("constant delay page wrong");

   property p_var_min;
      @(posedge ref_clk_in) disable iff (reset_in)
      int'(cyc_q) == PIPE_BP_RD && !bcm_b[CM_MODE_LSB + TM_CONST_BIT]
         && dm_b_addr[AW_DM-1 -: 2] == wp_n |-> int'(bcm_b[SLOT_BITS-1:0]) + DLY_8M <= int'(nxt);
   endproperty
   a_var_min: assert property (p_var_min) else $error("variable delay below minimum");

   property p_adv;
      @(posedge ref_clk_in) disable iff (reset_in)
      // a frame pulse restarts the slot count, so the offset is only checked off the pulse
      bp_out_strobe_out && !$past(frame_pulse_in)
         |-> (int'(cyc_q) + int'($past(bp_adv)) * ADV_STEP_CYC) % CH_CYC == 0;
   endproperty
   a_adv: assert property (p_adv) else $error("backplane advance offset wrong");
endmodule

// [verilog/tcd_mem.sv]
module tcd_mem #(
   parameter int DW = 16,
   parameter int AW = 11
) (
   input  wire logic          ref_clk_in,  // clock
   input  wire logic          a_we_in,     // port a write enable
   input  wire logic [AW-1:0] a_addr_in,   // port a address
   input  wire logic [DW-1:0] a_wdata_in,  // port a write data
   output logic      [DW-1:0] a_rdata_out, // port a registered read data
   input  wire logic [AW-1:0] b_addr_in,   // port b address
   output logic      [DW-1:0] b_rdata_out  // port b registered read data
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge ref_clk_in) begin
      if (a_we_in) begin
         mem[a_addr_in] <= a_wdata_in;
      end
      a_rdata_out <= mem[a_addr_in];
      b_rdata_out <= mem[b_addr_in];
   end
endmodule
